/* hw/arx_pkg.sv */
// package: constants, register map and state types for the async receiver
package arx_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_TICK_DIV = 8'h14;
  // control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DOUBLE_BIT = 1;
  localparam int CTRL_LEN_LSB = 4;
  // status field positions
  localparam int STAT_COMPLETE_BIT = 7;
  localparam int STAT_FRAMING_BIT = 4;
  localparam int STAT_OVERRUN_BIT = 3;
  // interrupt bits
  localparam int IRQ_FRAME_BIT = 0;
  localparam int IRQ_FERR_BIT = 1;
  localparam int IRQ_OVR_BIT = 2;
  // reset values
  localparam logic [3:0] LEN_RESET = 4'h8;
  localparam logic [15:0] TICK_DIV_RESET = 16'h0004;
  // sampling figures
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [3:0] LEN_MIN = 4'h5;
  localparam logic [3:0] LEN_MAX = 4'hA;
  localparam int FIFO_DEPTH = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_BITS = 2'b11
  } arx_state_type;

  // one buffered frame: data plus its framing and overrun flags
  typedef struct packed {
    logic [9:0] data;
    logic ferr;
    logic ovr;
  } arx_entry_type;

  typedef struct packed {
    logic [1:0] sync;
    logic line_prev;
    arx_state_type state;
    logic [15:0] tick_cnt;
    logic tick;
    logic [4:0] sample;
    logic [2:0] votes;
    logic [3:0] bit_idx;
    logic [9:0] shift;
    arx_entry_type [FIFO_DEPTH-1:0] fifo;
    logic [1:0] count;
    logic ovr_pend;
    logic enable;
    logic dbl;
    logic [3:0] len;
    logic [15:0] tick_div;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    logic hready;
    logic [31:0] hrdata;
    logic dph_valid;
    logic dph_write;
    logic [7:0] dph_addr;
  } arx_regs_type;
endpackage : arx_pkg

/* hw/arx_receiver.sv */
// async receiver: start detection, three-sample voting, two-deep buffer, AHB-Lite slave
// Notes on behaviour
// - line sampled sixteen times per bit, eight in double-speed mode
// - start search begins on high-to-low edge; first low sample is sample one
// - start checked on samples 8,9,10 normally, 4,5,6 in double speed
// - two or more high check samples reject the start as noise
// - valid start realigns bit timing; repeated on every frame
// - per-bit counter of sixteen or eight states names each sample
// - each bit decided by majority of its three centre samples
// - recovery covers data and parity through first stop bit only
// - low first stop bit sets the framing error flag for that frame
// - next start edge accepted right after last stop voting sample
// - frames of five to ten character plus parity bits supported
// - error flags travel in the buffer with their frame
// - clearing receiver enable aborts frame and empties the buffer
//
// Implementation choices: register access over AHB-Lite and the register offsets.
module arx_receiver
  import arx_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic SERIAL_IN_PIN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  output logic IRQ
);
  arx_regs_type r_ff, nxt_r;

  // voting window start for the current speed
  function automatic logic [4:0] vote_first(input logic dbl);
    return dbl ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  endfunction : vote_first

  // two of three samples decide the level
  function automatic logic majority(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority

  logic line;
  logic [4:0] per_bit;
  logic [4:0] vfirst;
  logic [3:0] len_eff;
  logic ahb_take;
  logic rd_data;
  logic wr_ctrl;
  logic push;
  logic [31:0] wval;
  logic bit_vote;

  assign line = r_ff.sync[1];
  assign per_bit = r_ff.dbl ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
  assign vfirst = vote_first(r_ff.dbl);
  // lengths outside the supported span are clamped so the frame always ends
  assign len_eff = (r_ff.len < LEN_MIN) ? LEN_MIN : ((r_ff.len > LEN_MAX) ? LEN_MAX : r_ff.len);
  assign ahb_take = HSEL & HTRANS[1] & HREADY;
  assign wval = HWDATA;
  // majority of the two held centre samples and the current one; a single
  // sample would let one noise hit flip the stop decision
  assign bit_vote = majority({r_ff.votes[1:0], line});

  // next-state logic for the whole block
  always_comb begin
    nxt_r = r_ff;
    push = 1'b0;
    rd_data = 1'b0;
    wr_ctrl = 1'b0;
    nxt_r.sync = {r_ff.sync[0], SERIAL_IN_PIN};
    nxt_r.tick = 1'b0;
    // sample tick generator; the divider stands in for the baud generator
    if (r_ff.tick_cnt >= r_ff.tick_div) begin
      nxt_r.tick_cnt = 16'h0000;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.tick_cnt = r_ff.tick_cnt + 16'h0001;
    end

    // receive state machine, one step per sample tick
    if (r_ff.tick && r_ff.enable) begin
      nxt_r.line_prev = line;
      case (r_ff.state)
        ST_IDLE: begin
          // this tick holds sample one, so the next tick examines sample two
          if (r_ff.line_prev && !line) begin
            nxt_r.state = ST_START;
            nxt_r.sample = 5'h02;
            nxt_r.votes = 3'h0;
          end
        end
        ST_START: begin
          nxt_r.sample = r_ff.sample + 5'h01;
          if (r_ff.sample >= vfirst && r_ff.sample <= vfirst + 5'h02) begin
            nxt_r.votes = {r_ff.votes[1:0], line};
          end
          if (r_ff.sample == vfirst + 5'h02) begin
            if (majority({r_ff.votes[1:0], line})) begin
              nxt_r.state = ST_IDLE;
            end else begin
              // realign: sample count restarts from the start-bit centre
              nxt_r.sample = vfirst + 5'h03;
              nxt_r.state = ST_BITS;
              nxt_r.bit_idx = 4'h0;
            end
          end
        end
        ST_BITS: begin
          nxt_r.sample = (r_ff.sample >= per_bit) ? 5'h01 : r_ff.sample + 5'h01;
          if (r_ff.sample >= vfirst && r_ff.sample <= vfirst + 5'h02) begin
            nxt_r.votes = {r_ff.votes[1:0], line};
          end
          if (r_ff.sample == vfirst + 5'h02) begin
            if (r_ff.bit_idx < len_eff) begin
              nxt_r.shift[r_ff.bit_idx] = majority({r_ff.votes[1:0], line});
              nxt_r.bit_idx = r_ff.bit_idx + 4'h1;
            end else begin
              // first stop bit: further stop bits are not examined
              push = 1'b1;
              nxt_r.state = ST_IDLE;
              nxt_r.line_prev = 1'b1;
            end
          end
        end
        default: nxt_r.state = ST_IDLE;
      endcase
    end

    // bus address phase captured for the data phase
    nxt_r.hready = 1'b1;
    nxt_r.dph_valid = ahb_take;
    if (ahb_take) begin
      nxt_r.dph_write = HWRITE;
      nxt_r.dph_addr = HADDR[7:0];
      if (!HWRITE && HADDR[7:0] == ADDR_DATA) begin
        rd_data = 1'b1;
      end
    end

    // read data mux; reading data pops the buffer with its flags
    nxt_r.hrdata = 32'h0000_0000;
    if (ahb_take && !HWRITE) begin
      case (HADDR[7:0])
        ADDR_CTRL: nxt_r.hrdata = {24'h00_0000, r_ff.len, 2'b00, r_ff.dbl, r_ff.enable};
        ADDR_STAT: begin
          nxt_r.hrdata[STAT_COMPLETE_BIT] = (r_ff.count != 2'b00);
          nxt_r.hrdata[STAT_FRAMING_BIT] = (r_ff.count != 2'b00) & r_ff.fifo[0].ferr;
          nxt_r.hrdata[STAT_OVERRUN_BIT] = (r_ff.count != 2'b00) & r_ff.fifo[0].ovr;
          nxt_r.hrdata[CTRL_DOUBLE_BIT] = r_ff.dbl;
        end
        ADDR_DATA: nxt_r.hrdata = {22'h0, r_ff.fifo[0].data};
        ADDR_IRQ_STAT: nxt_r.hrdata = {29'h0, r_ff.irq_stat};
        ADDR_IRQ_MASK: nxt_r.hrdata = {29'h0, r_ff.irq_mask};
        ADDR_TICK_DIV: nxt_r.hrdata = {16'h0000, r_ff.tick_div};
        default: nxt_r.hrdata = 32'h0000_0000;
      endcase
    end

    // buffer: pop on data read (software flush path), push at stop bit
    if (rd_data && r_ff.count != 2'b00) begin
      nxt_r.fifo[0] = r_ff.fifo[1];
      nxt_r.count = r_ff.count - 2'b01;
    end
    if (push) begin
      if (nxt_r.count == 2'(FIFO_DEPTH)) begin
        nxt_r.ovr_pend = 1'b1; // frame lost, flagged on the next stored one
      end else begin
        nxt_r.fifo[nxt_r.count[0]].data = nxt_r.shift & ((10'h001 << len_eff) - 10'h001);
        nxt_r.fifo[nxt_r.count[0]].ferr = ~bit_vote;
        nxt_r.fifo[nxt_r.count[0]].ovr = r_ff.ovr_pend;
        nxt_r.count = nxt_r.count + 2'b01;
        nxt_r.ovr_pend = 1'b0;
      end
    end

    // register writes in the data phase
    if (r_ff.dph_valid && r_ff.dph_write) begin
      case (r_ff.dph_addr)
        ADDR_CTRL: begin
          wr_ctrl = 1'b1;
          nxt_r.enable = wval[CTRL_ENABLE_BIT];
          nxt_r.dbl = wval[CTRL_DOUBLE_BIT];
          nxt_r.len = wval[CTRL_LEN_LSB +: 4];
        end
        ADDR_IRQ_STAT: nxt_r.irq_stat = r_ff.irq_stat & ~wval[2:0];
        ADDR_IRQ_MASK: nxt_r.irq_mask = wval[2:0];
        ADDR_TICK_DIV: nxt_r.tick_div = wval[15:0];
        default: nxt_r.irq_mask = r_ff.irq_mask;
      endcase
    end

    // events set over a same-cycle clear
    if (push) begin
      nxt_r.irq_stat[IRQ_FRAME_BIT] = 1'b1;
      nxt_r.irq_stat[IRQ_FERR_BIT] = nxt_r.irq_stat[IRQ_FERR_BIT] | ~bit_vote;
      nxt_r.irq_stat[IRQ_OVR_BIT] = nxt_r.irq_stat[IRQ_OVR_BIT] | nxt_r.ovr_pend;
    end

    // disable is immediate: frame dropped, buffer emptied
    if (wr_ctrl && !wval[CTRL_ENABLE_BIT]) begin
      nxt_r.state = ST_IDLE;
      nxt_r.count = 2'b00;
      nxt_r.ovr_pend = 1'b0;
      nxt_r.line_prev = 1'b0;
    end
    nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_mask);
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      r_ff <= '0;
      r_ff.sync <= 2'b11;
      r_ff.len <= LEN_RESET;
      r_ff.tick_div <= TICK_DIV_RESET;
      r_ff.hready <= 1'b1;
    end else if (CLK_EN) begin
      r_ff <= nxt_r;
    end
  end

  assign HREADYOUT = r_ff.hready;
  assign HRDATA = r_ff.hrdata;
  assign HRESP = 1'b0;
  assign IRQ = r_ff.irq;

  // start check sample numbers, relative to the first low sample
  sequence s_start_seen;
    CLK_EN && !wr_ctrl && r_ff.state == ST_IDLE && r_ff.tick && r_ff.enable
    && r_ff.line_prev && !line;
  endsequence

  a_start_numbering: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_start_seen |=> r_ff.sample == 5'h02 && r_ff.state == ST_START)
    else $error("start count did not follow sample one");

  a_noise_reject: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && r_ff.tick && r_ff.enable && r_ff.state == ST_START
     && r_ff.sample == vfirst + 5'h02 && majority({r_ff.votes[1:0], line}))
    |=> r_ff.state == ST_IDLE)
    else $error("noisy start was not rejected");

  a_start_accept: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && r_ff.tick && r_ff.enable && r_ff.state == ST_START
     && r_ff.sample == vfirst + 5'h02 && !majority({r_ff.votes[1:0], line}))
    |=> r_ff.state == ST_BITS && r_ff.bit_idx == 4'h0)
    else $error("valid start did not begin recovery");

  a_counter_range: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    r_ff.state == ST_BITS |-> r_ff.sample >= 5'h01 && r_ff.sample <= per_bit)
    else $error("bit state counter out of range");

  a_bit_count: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    r_ff.state == ST_BITS |-> r_ff.bit_idx <= LEN_MAX)
    else $error("too many bits recovered");

  a_ferr_stored: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && push && r_ff.count == 2'b00 && !rd_data && !wr_ctrl)
    |=> r_ff.fifo[0].ferr == ~$past((r_ff.votes[1] & r_ff.votes[0])
    | (line & (r_ff.votes[1] | r_ff.votes[0]))))
    else $error("framing flag does not match stop bit");

  a_flush_disable: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && wr_ctrl && !wval[CTRL_ENABLE_BIT]) |=> r_ff.count == 2'b00
    && r_ff.state == ST_IDLE)
    else $error("disable did not flush the receiver");

  a_pop_read: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && rd_data && r_ff.count == 2'b10 && !push && !wr_ctrl)
    |=> r_ff.count == 2'b01 && r_ff.fifo[0] == $past(r_ff.fifo[1]))
    else $error("data read did not advance buffer");

  a_sync_path: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    CLK_EN |=> r_ff.sync[1] == $past(r_ff.sync[0]))
    else $error("line synchroniser broken");

  // a data or parity bit reaching its last centre sample
  sequence s_data_vote;
    CLK_EN && r_ff.tick && r_ff.enable && r_ff.state == ST_BITS && !wr_ctrl
    && r_ff.sample == vfirst + 5'h02 && r_ff.bit_idx < len_eff;
  endsequence

  // the first stop bit reaching its last centre sample
  sequence s_stop_vote;
    CLK_EN && r_ff.tick && r_ff.enable && r_ff.state == ST_BITS && !wr_ctrl
    && r_ff.sample == vfirst + 5'h02 && r_ff.bit_idx >= len_eff;
  endsequence

  // vote written out another way so a broken majority helper shows up
  a_bit_vote: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_data_vote |=> r_ff.shift[$past(r_ff.bit_idx)]
    == $past((r_ff.votes[1] & r_ff.votes[0]) | (line & (r_ff.votes[1] | r_ff.votes[0]))))
    else $error("bit value does not follow the centre vote");

  // back to idle with the edge detector armed right after the stop vote
  a_stop_ready: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_stop_vote |=> r_ff.state == ST_IDLE && r_ff.line_prev)
    else $error("receiver not ready for the next start edge");

  // a low stop vote always raises the framing event, even over a clear
  a_stop_ferr: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_stop_vote ##0 !bit_vote |=> r_ff.irq_stat[IRQ_FERR_BIT])
    else $error("low stop bit did not raise the framing event");

  // no decision before the third check sample of the start bit
  a_start_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && r_ff.tick && r_ff.enable && r_ff.state == ST_START && !wr_ctrl
     && r_ff.sample < (r_ff.dbl ? 5'h06 : 5'h0A)) |=> r_ff.state == ST_START)
    else $error("start decided before its check samples");

  // the per-bit counter wraps after sixteen or eight states
  a_bit_wrap: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && r_ff.tick && r_ff.enable && r_ff.state == ST_BITS && !wr_ctrl
     && r_ff.sample == (r_ff.dbl ? 5'h08 : 5'h10)) |=> r_ff.sample == 5'h01)
    else $error("bit counter did not wrap at the bit end");

  // a rejected or finished frame waits for a fresh falling edge
  a_idle_wait: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && r_ff.state == ST_IDLE
     && !(r_ff.tick && r_ff.enable && r_ff.line_prev && !line)) |=> r_ff.state == ST_IDLE)
    else $error("receiver left idle without a falling edge");

  // unused upper bits of a short frame read as zero
  a_len_mask: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && push && r_ff.count == 2'b00 && !rd_data && !wr_ctrl)
    |=> (r_ff.fifo[0].data >> $past(len_eff)) == 10'h000)
    else $error("bits beyond the frame length stored");

  // a lost frame is reported with the next frame that is kept
  a_ovr_carried: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && push && r_ff.count == 2'b00 && !rd_data && !wr_ctrl)
    |=> r_ff.fifo[0].ovr == $past(r_ff.ovr_pend))
    else $error("overrun flag not stored with its frame");

  // software flushing relies on the complete bit tracking the buffer
  a_complete_read: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && ahb_take && !HWRITE && HADDR[7:0] == ADDR_STAT)
    |=> HRDATA[STAT_COMPLETE_BIT] == ($past(r_ff.count) != 2'b00))
    else $error("receive complete does not match the buffer");
endmodule : arx_receiver

/* testbench/arx_tx_model.sv */
// partner: remote serial transmitter that drives the receive line
module arx_tx_model (
  input wire logic clock,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;

  // line idles high so the first start bit is a clean falling edge
  initial line = 1'b1;

  // hold a level for n clocks; always entered just after a rising edge
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clock);
  endtask : hold

  // start, len bits lsb first, one stop of stop_n clocks; glitch upsets one centre sample
  task automatic send(input logic [9:0] d, input int len, input logic stop, input int stop_n,
                      input int spb, input logic glitch);
    hold(1'b0, spb);
    for (int i = 0; i < len; i++) begin
      hold(d[i], spb / 2);
      hold(d[i] ^ glitch, 1);
      hold(d[i], spb / 2 - 1);
    end
    hold(stop, stop_n); // single stop bit
  endtask : send
endmodule : arx_tx_model

/* testbench/test_async_rx_clock_data_recovery.sv */
// testbench: bus tasks and frame scenarios for the async receiver
module test_async_rx_clock_data_recovery
  import arx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic line;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  int mismatches = 0;
  int checked = 0;

  // 10 MHz system clock
  always #50 clock = ~clock;

  // single slave, so its ready is the bus ready
  arx_receiver uut (
    .CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(1'b1), .SERIAL_IN_PIN(line),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata),
    .HRESP(hresp), .IRQ(irq)
  );

  arx_tx_model u_tx (.clock(clock), .line(line));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one single transfer; ready and read data are taken as they stood at each rising edge
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rdv);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rdv = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(a, 1'b1, d, dummy);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0, v);
    chk(name, exp, v);
  endtask : rd

  task stop_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // watchdog: the whole sequence needs well under a millisecond
  initial begin
    #3000000;
    mismatches++;
    stop_test;
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(ADDR_CTRL, 32'h00000080, "ctrl reset");
    rd(ADDR_TICK_DIV, 32'h00000004, "tick reset");
    rd(8'h20, 32'h00000000, "unmapped");
    wr(8'h20, 32'hFFFFFFFF);
    // tick every clock keeps a bit at 16 clocks
    wr(ADDR_TICK_DIV, 32'h00000000);
    wr(ADDR_IRQ_MASK, 32'h00000007);
    wr(ADDR_CTRL, 32'h00000081);
    u_tx.send(10'h0A5, 8, 1'b1, 10, 16, 1'b1);
    u_tx.send(10'h03C, 8, 1'b0, 16, 16, 1'b0);
    u_tx.hold(1'b1, 16);
    chk("irq frames", 32'h1, {31'h0, irq});
    rd(ADDR_STAT, 32'h00000080, "stat head");
    rd(ADDR_DATA, 32'h000000A5, "data a5");
    rd(ADDR_STAT, 32'h00000090, "stat ferr");
    rd(ADDR_DATA, 32'h0000003C, "data 3c");
    rd(ADDR_STAT, 32'h00000000, "stat empty");
    rd(ADDR_IRQ_STAT, 32'h00000003, "irq stat");
    wr(ADDR_IRQ_STAT, 32'h00000003);
    rd(ADDR_IRQ_STAT, 32'h00000000, "irq clear");
    chk("irq low", 32'h0, {31'h0, irq});
    // double speed, five bits, only framing errors unmasked
    wr(ADDR_IRQ_MASK, 32'h00000002);
    wr(ADDR_CTRL, 32'h00000053);
    u_tx.send(10'h015, 5, 1'b1, 8, 8, 1'b1);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(ADDR_IRQ_STAT, 32'h00000001, "irq stat dbl");
    rd(ADDR_STAT, 32'h00000082, "stat dbl");
    rd(ADDR_DATA, 32'h00000015, "data dbl");
    // a short low spike is rejected, then a ten bit frame
    wr(ADDR_CTRL, 32'h000000A1);
    u_tx.hold(1'b0, 3);
    u_tx.hold(1'b1, 40);
    rd(ADDR_STAT, 32'h00000000, "stat spike");
    u_tx.send(10'h2B5, 10, 1'b1, 16, 16, 1'b0);
    rd(ADDR_DATA, 32'h000002B5, "data ten");
    // disabling drops a frame in the buffer and one in flight
    u_tx.send(10'h155, 10, 1'b1, 16, 16, 1'b0);
    u_tx.hold(1'b0, 40);
    wr(ADDR_CTRL, 32'h00000000);
    u_tx.hold(1'b1, 200);
    rd(ADDR_STAT, 32'h00000000, "stat off");
    wr(ADDR_CTRL, 32'h000000A1);
    // a frame left running would push within this wait
    u_tx.hold(1'b1, 200);
    rd(ADDR_STAT, 32'h00000000, "stat reenable");
    // a third frame with the buffer full is lost and marked on the next one
    wr(ADDR_IRQ_MASK, 32'h00000004);
    u_tx.send(10'h1C3, 10, 1'b1, 16, 16, 1'b0);
    u_tx.send(10'h2A6, 10, 1'b1, 16, 16, 1'b0);
    u_tx.send(10'h3FF, 10, 1'b1, 16, 16, 1'b0);
    chk("irq overrun", 32'h1, {31'h0, irq});
    rd(ADDR_DATA, 32'h000001C3, "data first");
    rd(ADDR_DATA, 32'h000002A6, "data second");
    u_tx.send(10'h05A, 10, 1'b1, 16, 16, 1'b0);
    rd(ADDR_STAT, 32'h00000088, "stat overrun");
    rd(ADDR_DATA, 32'h0000005A, "data after loss");
    rd(ADDR_IRQ_STAT, 32'h00000005, "irq stat ovr");
    stop_test;
  end
endmodule : test_async_rx_clock_data_recovery
